// [rtsc_top.sv]
// reset sequencer: reset release, strap latching, pad and clock-out drivers
// assumes pins are synchronous to clock except ext_reset_n assertion
`timescale 1ns/1ns
module rtsc_top (
   // clock and power-on reset of this block
   input wire logic clock,
   input wire logic srst,
   // reset sources
   input wire logic ext_reset_n,
   input wire logic wdog_reset_req,
   // strap inputs
   input wire logic tristate_select_n,
   input wire logic boot_select,
   // parallel_io_controller view of the pads
   input wire rtsc_pkg::rtsc_pad_s pio_pads,
   input wire logic clkout_gpio_sel,
   input wire logic clkout_gpio_value,
   input wire logic clkout_gpio_enable,
   // remap command from the memory controller
   input wire logic remap_cmd,
   // pad drivers
   output rtsc_pkg::rtsc_pad_s pad_drive,
   output logic clock_out_pin_o,
   output logic clock_out_pin_oe,
   // reset outputs to core and peripherals
   output logic periph_reset,
   output logic core_reset,
   output logic pc_load_zero,
   output logic [31:0] fetch_addr,
   // latched modes
   output rtsc_pkg::rtsc_strap_s straps,
   output logic remap_active
);
   logic sync1_reg;
   logic sync2_reg;
   logic ext_prev_reg;
   logic [rtsc_pkg::STRAP_CYCLES-1:0] tri_hist_reg;
   logic boot_last_reg;
   rtsc_pkg::rtsc_state_e state_reg;
   rtsc_pkg::rtsc_state_e state_next;
   logic [rtsc_pkg::CNT_W-1:0] cnt_reg;
   logic [rtsc_pkg::CNT_W-1:0] cnt_next;
   rtsc_pkg::rtsc_strap_s straps_reg;
   rtsc_pkg::rtsc_pad_s pad_reg;
   rtsc_pkg::rtsc_pad_s pad_next;
   logic periph_reset_reg;
   logic core_reset_reg;
   logic pc_zero_reg;
   logic [31:0] fetch_addr_reg;
   logic remap_reg;
   logic clk_run_reg;
   logic gpio_sel_reg;
   logic gpio_val_reg;
   logic gpio_en_reg;

   wire ext_low = !ext_reset_n;
   wire ext_rise = ext_prev_reg && ext_reset_n;
   wire hold = !sync2_reg || wdog_reset_req;
   wire cnt_done = cnt_reg == rtsc_pkg::CNT_W'(rtsc_pkg::DELAY_COUNT - 1);
   wire tri_latch = tri_hist_reg == rtsc_pkg::STRAP_ALL_LOW;
   wire drivers_off = hold || straps_reg.tristate_mode;
   // hold keeps the driver off until the newly latched tri-state mode is in force
   wire clk_pin_oe_next = !hold && !straps_reg.tristate_mode && (!gpio_sel_reg || gpio_en_reg);

   // release synchroniser, assertion bypasses it
   always_ff @(posedge clock or negedge ext_reset_n) begin
      if (!ext_reset_n) begin
         sync1_reg <= 1'b0; // RL6
         sync2_reg <= 1'b0;
      end else if (srst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= 1'b1; // RL19
         sync2_reg <= sync1_reg;
      end
   end

   // strap history only builds while the pin holds reset; relies on the board clocking it
   always_ff @(posedge clock) begin
      if (srst) begin
         ext_prev_reg <= 1'b0;
         tri_hist_reg <= '1;
         boot_last_reg <= rtsc_pkg::BOOT_MODE_RESET;
      end else begin
         ext_prev_reg <= ext_low;
         if (ext_low) begin
            tri_hist_reg <= {tri_hist_reg[rtsc_pkg::STRAP_CYCLES-2:0], tristate_select_n}; // RL12
            boot_last_reg <= boot_select;
         end
      end
   end

   // only the external rising edge updates straps; watchdog never does
   always_ff @(posedge clock) begin
      if (srst) begin
         straps_reg.boot_mode <= rtsc_pkg::BOOT_MODE_RESET;
         straps_reg.tristate_mode <= rtsc_pkg::TRI_MODE_RESET;
      end else if (ext_rise) begin // RL10 RL11
         straps_reg.tristate_mode <= tri_latch; // RL12
         straps_reg.boot_mode <= boot_last_reg; // RL17
      end
   end

   // sequencer from reset hold to first fetch
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         rtsc_pkg::ST_HOLD: begin
            cnt_next = '0;
            state_next = rtsc_pkg::ST_DELAY;
         end
         rtsc_pkg::ST_DELAY: begin
            cnt_next = cnt_reg + rtsc_pkg::CNT_W'(1);
            if (cnt_done) begin
               state_next = rtsc_pkg::ST_RUN; // RL8
            end
         end
         rtsc_pkg::ST_RUN: begin
            cnt_next = cnt_reg;
         end
         default: begin
            state_next = rtsc_pkg::ST_HOLD;
            cnt_next = '0;
         end
      endcase
      if (hold) begin // RL9
         state_next = rtsc_pkg::ST_HOLD;
         cnt_next = '0;
      end
   end

   always_ff @(posedge clock or negedge ext_reset_n) begin
      if (!ext_reset_n) begin
         state_reg <= rtsc_pkg::ST_HOLD;
         cnt_reg <= '0;
      end else if (srst) begin
         state_reg <= rtsc_pkg::ST_HOLD;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // reset outputs; peripherals leave reset once the release is synchronised
   always_ff @(posedge clock or negedge ext_reset_n) begin
      if (!ext_reset_n) begin
         periph_reset_reg <= 1'b1; // RL4
         core_reset_reg <= 1'b1;
         pc_zero_reg <= 1'b0;
         fetch_addr_reg <= rtsc_pkg::RESET_VECTOR;
      end else if (srst) begin
         periph_reset_reg <= 1'b1;
         core_reset_reg <= 1'b1;
         pc_zero_reg <= 1'b0;
         fetch_addr_reg <= rtsc_pkg::RESET_VECTOR;
      end else begin
         periph_reset_reg <= hold; // RL9
         core_reset_reg <= state_next != rtsc_pkg::ST_RUN; // RL8
         pc_zero_reg <= state_reg == rtsc_pkg::ST_DELAY && cnt_done && !hold; // RL5
         fetch_addr_reg <= rtsc_pkg::RESET_VECTOR; // RL5
      end
   end

   // remap: reset beats a command in the same cycle
   always_ff @(posedge clock or negedge ext_reset_n) begin
      if (!ext_reset_n) begin
         remap_reg <= 1'b0; // RL18
      end else if (srst || hold) begin
         remap_reg <= 1'b0; // RL18
      end else if (remap_cmd) begin
         remap_reg <= 1'b1;
      end
   end

   // pads: inputs during reset, all off in tri-state mode; tri-state strap is sampled only in reset
   always_comb begin
      pad_next.value = pio_pads.value;
      pad_next.enable = pio_pads.enable;
      if (drivers_off) begin
         pad_next.enable = '0; // RL13 RL15 RL16
      end
   end

   always_ff @(posedge clock or negedge ext_reset_n) begin
      if (!ext_reset_n) begin
         pad_reg <= '0; // RL16
      end else if (srst) begin
         pad_reg <= '0;
      end else begin
         pad_reg <= pad_next;
      end
   end

   // clock-out pin controls; gpio select comes back to the clock on any reset
   always_ff @(posedge clock or negedge ext_reset_n) begin
      if (!ext_reset_n) begin
         clk_run_reg <= 1'b0; // RL1
         gpio_sel_reg <= 1'b0;
         gpio_val_reg <= 1'b0;
         gpio_en_reg <= 1'b0;
         clock_out_pin_oe <= 1'b0;
      end else if (srst) begin
         clk_run_reg <= 1'b0;
         gpio_sel_reg <= 1'b0;
         gpio_val_reg <= 1'b0;
         gpio_en_reg <= 1'b0;
         clock_out_pin_oe <= 1'b0;
      end else begin
         clk_run_reg <= !hold; // RL2
         gpio_sel_reg <= clkout_gpio_sel && !hold; // RL3
         gpio_val_reg <= clkout_gpio_value;
         gpio_en_reg <= clkout_gpio_enable;
         clock_out_pin_oe <= clk_pin_oe_next; // RL13
      end
   end

   // the clock copy cannot come from a flop; run changes on rise while the clock is high, so the gating is not glitch-free
   assign clock_out_pin_o = gpio_sel_reg ? gpio_val_reg : (clock && clk_run_reg); // RL1 RL2 RL3

   assign pad_drive = pad_reg;
   assign periph_reset = periph_reset_reg;
   assign core_reset = core_reset_reg;
   assign pc_load_zero = pc_zero_reg;
   assign fetch_addr = fetch_addr_reg;
   assign straps = straps_reg;
   assign remap_active = remap_reg;
endmodule

// [rtsc_pkg.sv]
// reset and tri-state control: shared constants and types
// assumes one master clock; all pin inputs already synchronous to it except ext_reset_n assertion
// Function
// RL1 - clock output pin is held low while external reset is asserted
// RL2 - after reset the clock output pin carries the master clock
// RL3 - clock output pin becomes plain I/O only once the I/O controller selects it
// RL4 - any reset restores peripheral registers and makes the next fetch come from zero
// RL5 - only the program counter is forced, to address zero
// RL6 - external reset asserts asynchronously, release is synchronised to the master clock
// RL7 - board keeps the master clock valid for the last 10 cycles of reset
// RL8 - first instruction fetch comes 80 cycles after external reset rises
// RL9 - watchdog reset acts the same as the external reset input
// RL10 - watchdog reset does not resample straps; latched modes stay
// RL11 - external reset with watchdog request is handled as external, straps sampled
// RL12 - tri-state mode latched when select is low for the last 10 reset cycles
// RL13 - in tri-state mode every output driver is disabled
// RL14 - board holds tri-state select high during reset for normal use
// RL15 - tri-state select shares pad with line 21 and usart1 tx; strap only in reset
// RL16 - every peripheral pin comes out of reset as an input
// RL17 - boot memory selection latched from boot select during last 10 reset cycles
// RL18 - an address remap is undone only by internal or external reset
// RL19 - external reset release passes a two-stage synchroniser
package rtsc_pkg;
   localparam int PAD_COUNT = 32;
   localparam int STRAP_CYCLES = 10;
   localparam int SYNC_STAGES = 2;
   localparam int FETCH_DELAY_CYCLES = 80;
   // counted after the synchroniser, so its own delay is taken off
   localparam int DELAY_COUNT = FETCH_DELAY_CYCLES - SYNC_STAGES;
   localparam int CNT_W = 7;
   localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
   localparam logic [STRAP_CYCLES-1:0] STRAP_ALL_LOW = '0;
   localparam int TRI_PAD_INDEX = 21;
   localparam logic BOOT_MODE_RESET = 1'b1;
   localparam logic TRI_MODE_RESET = 1'b0;

   typedef enum logic [1:0] {
      ST_HOLD,
      ST_DELAY,
      ST_RUN
   } rtsc_state_e;

   typedef struct packed {
      logic [PAD_COUNT-1:0] value;
      logic [PAD_COUNT-1:0] enable;
   } rtsc_pad_s;

   typedef struct packed {
      logic boot_mode;
      logic tristate_mode;
   } rtsc_strap_s;
endpackage

// [rtsc_asserts.sv]
// checker: reset release, fetch delay and strap latching at the top ports
// bound to rtsc_top; one clock, srst disables every check
`timescale 1ns/1ns
module rtsc_asserts (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // pins and requests
   input wire logic ext_reset_n,
   input wire logic wdog_reset_req,
   input wire logic tristate_select_n,
   input wire logic boot_select,
   // outputs
   input wire rtsc_pkg::rtsc_pad_s pad_drive,
   input wire logic clock_out_pin_o,
   input wire logic clock_out_pin_oe,
   input wire logic periph_reset,
   input wire logic core_reset,
   input wire logic pc_load_zero,
   input wire rtsc_pkg::rtsc_strap_s straps,
   input wire logic remap_active
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   property p_pin_low;
      !ext_reset_n |-> !clock_out_pin_o && !clock_out_pin_oe && pad_drive.enable == '0;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("pins driven in reset");
   property p_tri_off;
      straps.tristate_mode |-> pad_drive.enable == '0 && !clock_out_pin_oe;
   endproperty
   a_tri_off: assert property (p_tri_off) else $error("driver on in tri-state");
   // edge 0 sees the pin high, then two synchroniser stages
   property p_sync;
      $rose(ext_reset_n) && !wdog_reset_req |-> periph_reset [*3] ##1 !periph_reset;
   endproperty
   a_sync: assert property (p_sync) else $error("release not synchronised");
   property p_fetch;
      $rose(ext_reset_n) |-> ##80 core_reset ##1 (!core_reset && pc_load_zero);
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch delay wrong");
   property p_keep;
      ext_reset_n && $past(ext_reset_n) |=> $stable(straps);
   endproperty
   a_keep: assert property (p_keep) else $error("straps changed");
   // consecutive edges with pin and strap both low; saturates
   logic [3:0] tri_run_reg;
   always_ff @(posedge clock) begin
      if (srst) begin
         tri_run_reg <= 4'h0;
      end else if (!tristate_select_n && !ext_reset_n) begin
         tri_run_reg <= (tri_run_reg == 4'hF) ? tri_run_reg : tri_run_reg + 4'h1;
      end else begin
         tri_run_reg <= 4'h0;
      end
   end
   property p_tri_on;
      $rose(ext_reset_n) && tri_run_reg >= 4'(rtsc_pkg::STRAP_CYCLES) |=> straps.tristate_mode;
   endproperty
   a_tri_on: assert property (p_tri_on) else $error("tri-state not latched");
   property p_boot;
      $rose(ext_reset_n) |=> straps.boot_mode == $past(boot_select, 2);
   endproperty
   a_boot: assert property (p_boot) else $error("boot mode wrong");
   property p_remap;
      !ext_reset_n || wdog_reset_req |=> !remap_active && periph_reset;
   endproperty
   a_remap: assert property (p_remap) else $error("reset missed");
endmodule
bind rtsc_top rtsc_asserts u_chk (.clock, .srst, .ext_reset_n, .wdog_reset_req,
   .tristate_select_n, .boot_select, .pad_drive, .clock_out_pin_o, .clock_out_pin_oe,
   .periph_reset, .core_reset, .pc_load_zero, .straps, .remap_active);

// [rtsc_board.sv]
// board model: reset switch, strap resistors, emulator probe
// commanded by the bench off the falling edge
`timescale 1ns/1ns
module rtsc_board (
   // commands
   input wire logic hold,
   input wire logic tri_req,
   input wire logic boot_val,
   // pins
   output logic ext_reset_n,
   output logic tristate_select_n,
   output logic boot_select
);
   assign ext_reset_n = !hold;
   // pull-up wins unless the probe pulls low during reset
   assign tristate_select_n = !(hold && tri_req);
   assign boot_select = boot_val;
endmodule

// [testbench.sv]
// bench: board model around rtsc_top, random pads and straps
// one 20 MHz clock; inputs change on the falling edge
`timescale 1ns/1ns
module testbench;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic hold = 1'b1;
   logic tri_req = 1'b0;
   logic boot_val = 1'b1;
   logic wdog = 1'b0;
   logic remap = 1'b0;
   logic sel = 1'b0;
   logic gval = 1'b0;
   logic gen = 1'b0;
   logic [31:0] seed = 32'h00008CB8;
   rtsc_pkg::rtsc_pad_s pads = '0;
   rtsc_pkg::rtsc_pad_s pdrv;
   rtsc_pkg::rtsc_strap_s st;
   logic ext_n, tri_n, boot, co, coe, prst, crst, pcz, ract;
   logic [31:0] fa;
   int fails = 0;
   int n_compared = 0;
   always #25 clock = ~clock;
   rtsc_board board (.hold, .tri_req, .boot_val, .ext_reset_n(ext_n),
      .tristate_select_n(tri_n), .boot_select(boot));
   rtsc_top DUT (.clock, .srst, .ext_reset_n(ext_n), .wdog_reset_req(wdog),
      .tristate_select_n(tri_n), .boot_select(boot), .pio_pads(pads), .clkout_gpio_sel(sel),
      .clkout_gpio_value(gval), .clkout_gpio_enable(gen), .remap_cmd(remap),
      .pad_drive(pdrv), .clock_out_pin_o(co), .clock_out_pin_oe(coe), .periph_reset(prst),
      .core_reset(crst), .pc_load_zero(pcz), .fetch_addr(fa), .straps(st),
      .remap_active(ract));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [31:0] exp_en(input logic t, input logic [31:0] e);
      return t ? 32'h00000000 : e;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic stop_test;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge clock);
   endtask
   // e below zero: only a bounded wait
   task automatic wait_core(input int e);
      int n;
      n = 0;
      while (crst !== 1'b0 && n < 200) begin
         tick(1);
         n++;
      end
      if (n == 200) begin
         fails++;
         stop_test();
      end else if (e >= 0) begin
         chk(32'(n), 32'(e));
      end
   endtask
   task automatic ext_cycle(input logic t, input logic b, input logic w);
      hold = 1'b1;
      tri_req = t;
      boot_val = b;
      wdog = w;
      tick(1);
      wdog = 1'b0;
      tick(10);
      @(posedge clock);
      #1;
      chk(32'(co), 32'h0);
      chk(pdrv.enable, 32'h0);
      tick(1);
      hold = 1'b0;
      wait_core(rtsc_pkg::FETCH_DELAY_CYCLES + 1);
      chk(32'(pcz), 32'h1);
      chk(fa, 32'h0);
      chk(32'(st), {30'h0, b, t});
      seed = xs(seed);
      pads.value = seed;
      seed = xs(seed);
      pads.enable = seed;
      tick(2);
      chk(pdrv.enable, exp_en(t, pads.enable));
      chk(pdrv.value, pads.value);
      @(posedge clock);
      #1;
      chk(32'({co, coe}), 32'({1'b1, !t}));
      tick(1);
      $display("ext reset test done");
   endtask
   initial begin
      tick(2);
      srst = 1'b0;
      for (int i = 0; i < 5; i++) begin
         seed = xs(seed);
         ext_cycle(i[0], seed[0], i[1]);
      end
      remap = 1'b1;
      tick(1);
      remap = 1'b0;
      chk(32'(ract), 32'h1);
      boot_val = ~boot_val;
      wdog = 1'b1;
      tick(1);
      wdog = 1'b0;
      chk(32'({prst, crst, ract}), 32'h6);
      wait_core(-1);
      chk(32'(st), {30'h0, ~boot_val, 1'b0});
      seed = xs(seed);
      sel = 1'b1;
      gval = seed[0];
      gen = 1'b1;
      tick(2);
      chk(32'({co, coe}), 32'({seed[0], 1'b1}));
      gen = 1'b0;
      tick(2);
      chk(32'(coe), 32'h0);
      $display("watchdog and gpio tests done");
      stop_test();
   end
endmodule
